// >>> hcr_pkg.sv
// Shared offsets, reset values and encodings of the hub configuration byte map
package hcr_pkg;
    // Identifier and configuration locations
    localparam logic [7:0] OFS_VENDOR_LOW = 8'h00;
    localparam logic [7:0] OFS_VENDOR_HIGH = 8'h01;
    localparam logic [7:0] OFS_PRODUCT_LOW = 8'h02;
    localparam logic [7:0] OFS_PRODUCT_HIGH = 8'h03;
    localparam logic [7:0] OFS_RELEASE_LOW = 8'h04;
    localparam logic [7:0] OFS_RELEASE_HIGH = 8'h05;
    localparam logic [7:0] OFS_CFG_ONE = 8'h06;
    localparam logic [7:0] OFS_CFG_TWO = 8'h07;
    localparam logic [7:0] OFS_CFG_THREE = 8'h08;
    localparam logic [7:0] OFS_FIXED_PORTS = 8'h09;
    localparam logic [7:0] OFS_OFF_SELF = 8'h0A;
    localparam logic [7:0] OFS_OFF_BUS = 8'h0B;
    localparam logic [7:0] OFS_BUDGET_SELF = 8'h0C;
    localparam logic [7:0] OFS_BUDGET_BUS = 8'h0D;
    localparam logic [7:0] OFS_CURRENT_SELF = 8'h0E;
    localparam logic [7:0] OFS_CURRENT_BUS = 8'h0F;
    localparam logic [7:0] OFS_SETTLE_TIME = 8'h10;
    localparam logic [7:0] OFS_LANG_HIGH = 8'h11;
    localparam logic [7:0] OFS_LANG_LOW = 8'h12;
    // Text regions: three length bytes, then three contiguous areas
    localparam logic [7:0] OFS_MAKER_LEN = 8'h13;
    localparam logic [7:0] OFS_PRODUCT_LEN = 8'h14;
    localparam logic [7:0] OFS_SERIAL_LEN = 8'h15;
    localparam logic [7:0] OFS_MAKER_AREA = 8'h16;
    localparam logic [7:0] OFS_PRODUCT_AREA = 8'h54;
    localparam logic [7:0] OFS_SERIAL_AREA = 8'h92;
    localparam logic [7:0] OFS_SERIAL_LAST = 8'hCF;
    // Upper locations
    localparam logic [7:0] OFS_CHARGE_EN = 8'hD0;
    localparam logic [7:0] OFS_RSVD_E0 = 8'hE0;
    localparam logic [7:0] OFS_RSVD_F5 = 8'hF5;
    localparam logic [7:0] OFS_BOOST_UP = 8'hF6;
    localparam logic [7:0] OFS_BOOST_DOWN = 8'hF8;
    localparam logic [7:0] OFS_PAIR_SWAP = 8'hFA;
    localparam logic [7:0] OFS_MAP_12 = 8'hFB;
    localparam logic [7:0] OFS_MAP_34 = 8'hFC;
    localparam logic [7:0] OFS_STATUS_CMD = 8'hFF;
    // Values after reset and built-in defaults
    localparam logic [7:0] RST_IMAGE = 8'h00;
    localparam logic [7:0] DEF_CFG_ONE = 8'h9B;
    localparam logic [7:0] DEF_CFG_TWO = 8'h20;
    localparam logic [7:0] DEF_CFG_THREE = 8'h02;
    localparam logic [7:0] DEF_BUDGET_SELF = 8'h01;
    localparam logic [7:0] DEF_BUDGET_BUS = 8'h32;
    localparam logic [7:0] DEF_SETTLE_TIME = 8'h32;
    // Sizes
    localparam int MAP_DEPTH = 256;
    localparam int PORT_COUNT = 4;
    // Configuration source, in select-pin order
    typedef enum logic [1:0] {SRC_INT_SELF, SRC_SMBUS, SRC_INT_BUS, SRC_EEPROM} hcr_source_e;
endpackage

// >>> hcr_strap_sampler.sv
// Catches the configuration-source select pins once after reset release
`timescale 1ns/10ps
module hcr_strap_sampler
    import hcr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Select pins
    input wire logic [1:0] cfgSelPins,
    // Sampled result
    output hcr_source_e cfgSource,
    output logic strapValid,
    output logic sampled
);
    // First edge after release takes the pins; later edges hold them
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfgSource <= SRC_INT_SELF;
            sampled <= 1'b0;
            strapValid <= 1'b0;
        end else begin
            strapValid <= !sampled;
            if (!sampled) begin
                cfgSource <= hcr_source_e'(cfgSelPins);
                sampled <= 1'b1;
            end
        end
    end

    a_strap_taken_once:
    assert property (@(posedge clk) disable iff (!rst_b)
        strapValid |-> (cfgSource == hcr_source_e'($past(cfgSelPins))) ##1 !strapValid)
        else $error("select pins not captured exactly once");
endmodule

// >>> hcr_charge_drive.sv
// Per-port power drive from the charge enable byte or the charge straps
`timescale 1ns/10ps
module hcr_charge_drive
    import hcr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic configDone,
    input wire logic strapsEnabled,
    input wire logic [7:0] chargeByte,
    input wire logic [PORT_COUNT-1:0] chargeEnableStrap,
    // Drive outputs, port 1 in bit 0
    output logic [PORT_COUNT-1:0] portPowerDrive
);
    genvar p;
    generate
        for (p = 0; p < PORT_COUNT; p++) begin : gPort
            // Power stays off until configuration is complete
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    portPowerDrive[p] <= 1'b0;
                end else begin
                    portPowerDrive[p] <= configDone &&
                        (strapsEnabled ? chargeEnableStrap[p] : chargeByte[p+1]);
                end
            end

            a_charge_port_drive:
            assert property (@(posedge clk) disable iff (!rst_b)
                (configDone && !strapsEnabled) |=> portPowerDrive[p] == $past(chargeByte[p+1]))
                else $error("port drive does not follow charge enable bit");
        end
    endgenerate
endmodule

// >>> hcr_config_register_set.sv
// Byte-wide hub configuration register set loaded by serial EEPROM or SMBus master
`timescale 1ns/10ps
module hcr_config_register_set
    import hcr_pkg::*;
#(
    // Built-in identifiers; values are arbitrary
    parameter logic [15:0] DEF_VENDOR_ID = 16'hABCD,
    parameter logic [15:0] DEF_PRODUCT_ID = 16'h5A6B,
    parameter logic [15:0] DEF_RELEASE = 16'h0100
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Straps
    input wire logic [1:0] cfgSelPins,
    input wire logic [PORT_COUNT-1:0] chargeEnableStrap,
    // SMBus slave write path
    input wire logic smbWrEn,
    input wire logic [7:0] smbAddr,
    input wire logic [7:0] smbData,
    // EEPROM load write path
    input wire logic eepWrEn,
    input wire logic [7:0] eepAddr,
    input wire logic [7:0] eepData,
    // External load finished
    input wire logic loadComplete,
    // Read port
    input wire logic rdEn,
    input wire logic [7:0] rdAddr,
    output logic [7:0] rdData,
    output logic rdValid,
    // Configuration state
    output logic configDone,
    output hcr_source_e cfgSource,
    // Values used by the hub
    output logic [15:0] vendorId,
    output logic [15:0] productId,
    output logic [15:0] releaseNumber,
    output logic [7:0] cfgByteOne,
    output logic [7:0] cfgByteTwo,
    output logic [7:0] cfgByteThree,
    output logic [7:0] powerBudgetSelf,
    output logic [7:0] powerBudgetBus,
    output logic [7:0] powerSettleTime,
    output logic [PORT_COUNT-1:0] portPowerDrive
);
    logic [7:0] regFile [0:MAP_DEPTH-1];
    logic strapValid;
    logic strapSampled;

    // Source selection captured once after reset
    hcr_strap_sampler uStrap (
        .clk(clk),
        .rst_b(rst_b),
        .cfgSelPins(cfgSelPins),
        .cfgSource(cfgSource),
        .strapValid(strapValid),
        .sampled(strapSampled)
    );

    // Which locations hold storage; the gaps read as zero
    function automatic logic isImplemented(input logic [7:0] a);
        isImplemented = (a <= OFS_CHARGE_EN) || (a == OFS_RSVD_E0) || (a >= OFS_RSVD_F5);
    endfunction

    // Built-in image used when the hub configures itself
    function automatic logic [7:0] defaultOf(input logic [7:0] a);
        case (a)
            OFS_VENDOR_LOW: defaultOf = DEF_VENDOR_ID[7:0];
            OFS_VENDOR_HIGH: defaultOf = DEF_VENDOR_ID[15:8];
            OFS_PRODUCT_LOW: defaultOf = DEF_PRODUCT_ID[7:0];
            OFS_PRODUCT_HIGH: defaultOf = DEF_PRODUCT_ID[15:8];
            OFS_RELEASE_LOW: defaultOf = DEF_RELEASE[7:0];
            OFS_RELEASE_HIGH: defaultOf = DEF_RELEASE[15:8];
            OFS_CFG_ONE: defaultOf = DEF_CFG_ONE;
            OFS_CFG_TWO: defaultOf = DEF_CFG_TWO;
            OFS_CFG_THREE: defaultOf = DEF_CFG_THREE;
            OFS_BUDGET_SELF: defaultOf = DEF_BUDGET_SELF;
            OFS_BUDGET_BUS: defaultOf = DEF_BUDGET_BUS;
            OFS_CURRENT_SELF: defaultOf = DEF_BUDGET_SELF;
            OFS_CURRENT_BUS: defaultOf = DEF_BUDGET_BUS;
            OFS_SETTLE_TIME: defaultOf = DEF_SETTLE_TIME;
            default: defaultOf = RST_IMAGE;
        endcase
    endfunction

    // Mode decode from the captured straps
    wire modeSmbus = strapSampled && (cfgSource == SRC_SMBUS);
    wire modeEeprom = strapSampled && (cfgSource == SRC_EEPROM);
    wire strapsEnabled = strapSampled && !modeSmbus && !modeEeprom;
    wire loadDefaults = strapValid &&
        ((cfgSource == SRC_INT_SELF) || (cfgSource == SRC_INT_BUS));

    // Accept only the path the straps chose; EEPROM never reaches the top byte
    wire smbAccept = smbWrEn && modeSmbus;
    wire eepAccept = eepWrEn && modeEeprom && (eepAddr != OFS_STATUS_CMD);

    // One merged write port so both paths see the same map
    wire wrEn = smbAccept || eepAccept;
    wire [7:0] wrAddr = smbAccept ? smbAddr : eepAddr;
    wire [7:0] wrData = smbAccept ? smbData : eepData;
    wire wrHit = wrEn && isImplemented(wrAddr);

    // Storage, one byte per location
    genvar i;
    generate
        for (i = 0; i < MAP_DEPTH; i++) begin : gByte
            wire [7:0] myAddr = 8'(i);
            wire [7:0] next_byte = loadDefaults ? defaultOf(myAddr) : wrData;
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    regFile[i] <= RST_IMAGE;
                end else if (loadDefaults || (wrHit && wrAddr == myAddr)) begin
                    regFile[i] <= next_byte;
                end
            end
        end
    endgenerate

    // Read port answers one cycle after the request
    wire [7:0] next_rdData = isImplemented(rdAddr) ? regFile[rdAddr] : RST_IMAGE;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData <= RST_IMAGE;
            rdValid <= 1'b0;
        end else begin
            rdValid <= rdEn;
            if (rdEn) begin
                rdData <= next_rdData;
            end
        end
    end

    // Done on the built-in load, or when the external loader says so
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            configDone <= 1'b0;
        end else if (loadDefaults || ((modeSmbus || modeEeprom) && loadComplete)) begin
            configDone <= 1'b1;
        end
    end

    // Identifier pairs, low byte first
    assign vendorId = {regFile[OFS_VENDOR_HIGH], regFile[OFS_VENDOR_LOW]};
    assign productId = {regFile[OFS_PRODUCT_HIGH], regFile[OFS_PRODUCT_LOW]};
    assign releaseNumber = {regFile[OFS_RELEASE_HIGH], regFile[OFS_RELEASE_LOW]};

    // Configuration and power bytes straight from storage
    assign cfgByteOne = regFile[OFS_CFG_ONE];
    assign cfgByteTwo = regFile[OFS_CFG_TWO];
    assign cfgByteThree = regFile[OFS_CFG_THREE];
    assign powerBudgetSelf = regFile[OFS_BUDGET_SELF];
    assign powerBudgetBus = regFile[OFS_BUDGET_BUS];
    assign powerSettleTime = regFile[OFS_SETTLE_TIME];

    // Text regions: one length byte each, areas back to back up to the serial end
    wire [7:0] makerTextLength = regFile[OFS_MAKER_LEN];
    wire [7:0] productTextLength = regFile[OFS_PRODUCT_LEN];
    wire [7:0] serialTextLength = regFile[OFS_SERIAL_LEN];
    wire inMakerArea = (wrAddr >= OFS_MAKER_AREA) && (wrAddr < OFS_PRODUCT_AREA);
    wire inProductArea = (wrAddr >= OFS_PRODUCT_AREA) && (wrAddr < OFS_SERIAL_AREA);
    wire inSerialArea = (wrAddr >= OFS_SERIAL_AREA) && (wrAddr <= OFS_SERIAL_LAST);
    wire textAreaWrite = wrHit && (inMakerArea || inProductArea || inSerialArea);

    // Port power follows the charge enable byte, or the straps when enabled
    hcr_charge_drive uCharge (
        .clk(clk),
        .rst_b(rst_b),
        .configDone(configDone),
        .strapsEnabled(strapsEnabled),
        .chargeByte(regFile[OFS_CHARGE_EN]),
        .chargeEnableStrap(chargeEnableStrap),
        .portPowerDrive(portPowerDrive)
    );

    // Checks

    a_write_read_back:
    assert property (@(posedge clk) disable iff (!rst_b)
        (wrHit && !loadDefaults) |=> regFile[$past(wrAddr)] == $past(wrData))
        else $error("written byte not stored");

    a_read_answer:
    assert property (@(posedge clk) disable iff (!rst_b)
        (rdEn && !isImplemented(rdAddr)) |=> rdValid && rdData == 8'h00)
        else $error("gap location did not read zero");

    a_vendor_high_byte:
    assert property (@(posedge clk) disable iff (!rst_b)
        (smbAccept && smbAddr == OFS_VENDOR_HIGH) |=> vendorId[15:8] == $past(smbData))
        else $error("vendor high byte not at second location");

    a_product_low_eep:
    assert property (@(posedge clk) disable iff (!rst_b)
        (eepAccept && eepAddr == OFS_PRODUCT_LOW) |=> productId[7:0] == $past(eepData))
        else $error("product low byte not loaded from EEPROM path");

    a_release_high_smb:
    assert property (@(posedge clk) disable iff (!rst_b)
        (smbAccept && smbAddr == OFS_RELEASE_HIGH) |=> releaseNumber[15:8] == $past(smbData))
        else $error("release high byte misplaced");

    a_defaults_config:
    assert property (@(posedge clk) disable iff (!rst_b)
        loadDefaults |=> cfgByteOne == 8'h9B && cfgByteTwo == 8'h20 && cfgByteThree == 8'h02)
        else $error("built-in configuration bytes wrong");

    a_defaults_power:
    assert property (@(posedge clk) disable iff (!rst_b)
        loadDefaults |=> powerBudgetSelf == 8'h01 && powerBudgetBus == 8'h32
            && powerSettleTime == 8'h32)
        else $error("built-in power values wrong");

    a_status_eep_blocked:
    assert property (@(posedge clk) disable iff (!rst_b)
        (eepWrEn && !smbWrEn && !loadDefaults) |=> $stable(regFile[OFS_STATUS_CMD]))
        else $error("EEPROM path changed status byte");

    a_external_no_defaults:
    assert property (@(posedge clk) disable iff (!rst_b)
        (strapValid && (cfgSource == SRC_SMBUS || cfgSource == SRC_EEPROM))
            |=> !strapsEnabled && cfgByteOne == 8'h00 && !configDone)
        else $error("external mode took built-in defaults");

    // Text areas never spill into the length bytes
    a_text_length_kept:
    assert property (@(posedge clk) disable iff (!rst_b)
        textAreaWrite |=> $stable({makerTextLength, productTextLength, serialTextLength}))
        else $error("text area write disturbed a length byte");

    a_maker_length_write:
    assert property (@(posedge clk) disable iff (!rst_b)
        (wrHit && wrAddr == OFS_MAKER_LEN) |=> makerTextLength == $past(wrData))
        else $error("maker text length not stored");

    a_serial_length_write:
    assert property (@(posedge clk) disable iff (!rst_b)
        (wrHit && wrAddr == OFS_SERIAL_LEN) |=> serialTextLength == $past(wrData))
        else $error("serial text length not stored");

    // Only the chosen path writes; the other one is dropped silently
    a_smb_path_refused:
    assert property (@(posedge clk) disable iff (!rst_b)
        (smbWrEn && !modeSmbus && !eepAccept && !loadDefaults)
            |=> regFile[$past(smbAddr)] == $past(regFile[smbAddr]))
        else $error("unselected SMBus write changed the map");

    a_eep_path_refused:
    assert property (@(posedge clk) disable iff (!rst_b)
        (eepWrEn && !modeEeprom && !smbAccept && !loadDefaults)
            |=> regFile[$past(eepAddr)] == $past(regFile[eepAddr]))
        else $error("unselected EEPROM write changed the map");

    // Done waits for the loader in external modes, then stays until reset
    a_done_external_wait:
    assert property (@(posedge clk) disable iff (!rst_b)
        ((modeSmbus || modeEeprom) && !loadComplete && !configDone) |=> !configDone)
        else $error("external configuration finished without the loader");

    a_done_sticky:
    assert property (@(posedge clk) disable iff (!rst_b)
        configDone |=> configDone)
        else $error("configuration done dropped before reset");

    // Read port answers once per request and holds its data
    a_read_valid_rise:
    assert property (@(posedge clk) disable iff (!rst_b)
        rdEn |=> rdValid)
        else $error("read answer missing");

    a_read_valid_fall:
    assert property (@(posedge clk) disable iff (!rst_b)
        !rdEn |=> !rdValid)
        else $error("read answer without request");

    a_read_data_holds:
    assert property (@(posedge clk) disable iff (!rst_b)
        !rdEn |=> $stable(rdData))
        else $error("read data moved without request");

    a_read_stored_byte:
    assert property (@(posedge clk) disable iff (!rst_b)
        (rdEn && isImplemented(rdAddr)) |=> rdData == $past(regFile[rdAddr]))
        else $error("read data differs from stored byte");

    // Identifier halves from both paths
    a_vendor_low_eep:
    assert property (@(posedge clk) disable iff (!rst_b)
        (eepAccept && eepAddr == OFS_VENDOR_LOW) |=> vendorId[7:0] == $past(eepData))
        else $error("vendor low byte not at first location");

    a_product_high_smb:
    assert property (@(posedge clk) disable iff (!rst_b)
        (smbAccept && smbAddr == OFS_PRODUCT_HIGH) |=> productId[15:8] == $past(smbData))
        else $error("product high byte misplaced");

    a_release_low_eep:
    assert property (@(posedge clk) disable iff (!rst_b)
        (eepAccept && eepAddr == OFS_RELEASE_LOW) |=> releaseNumber[7:0] == $past(eepData))
        else $error("release low byte misplaced");

    // Built-in image, the top byte and the strap choice
    a_default_identifiers:
    assert property (@(posedge clk) disable iff (!rst_b)
        loadDefaults |=> vendorId == DEF_VENDOR_ID && productId == DEF_PRODUCT_ID
            && releaseNumber == DEF_RELEASE)
        else $error("built-in identifiers wrong");

    a_defaults_current:
    assert property (@(posedge clk) disable iff (!rst_b)
        loadDefaults |=> regFile[OFS_CURRENT_SELF] == 8'h01
            && regFile[OFS_CURRENT_BUS] == 8'h32)
        else $error("built-in controller current wrong");

    a_defaults_upper_zero:
    assert property (@(posedge clk) disable iff (!rst_b)
        loadDefaults |=> regFile[OFS_CHARGE_EN] == 8'h00
            && regFile[OFS_STATUS_CMD] == 8'h00)
        else $error("built-in image not zero in upper bytes");

    a_status_smb_write:
    assert property (@(posedge clk) disable iff (!rst_b)
        (smbAccept && smbAddr == OFS_STATUS_CMD)
            |=> regFile[OFS_STATUS_CMD] == $past(smbData))
        else $error("status byte not writable over SMBus");

    a_straps_internal_only:
    assert property (@(posedge clk) disable iff (!rst_b)
        strapsEnabled |-> (cfgSource == SRC_INT_SELF || cfgSource == SRC_INT_BUS))
        else $error("straps enabled in an external mode");

    a_source_locked:
    assert property (@(posedge clk) disable iff (!rst_b)
        strapSampled |=> $stable(cfgSource))
        else $error("captured source changed");
endmodule

// >>> hcr_cfg_host.sv
// Configuring host model: SMBus master or EEPROM loader writing the byte map
`timescale 1ns/10ps
module hcr_cfg_host
    import hcr_pkg::*;
(
    // Clock
    input wire logic clk,
    // Write paths
    output logic smbWrEn,
    output logic [7:0] smbAddr,
    output logic [7:0] smbData,
    output logic eepWrEn,
    output logic [7:0] eepAddr,
    output logic [7:0] eepData,
    // Load finished
    output logic loadComplete
);
    // Quiet lines at time zero
    initial begin
        {smbWrEn, eepWrEn, loadComplete} = 3'h0;
        {smbAddr, smbData, eepAddr, eepData} = 32'h0;
    end

    // One-cycle strobe; idle lines show the inverse so stale values never look valid
    task automatic writeByte(input logic viaEep, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        smbWrEn <= !viaEep;
        eepWrEn <= viaEep;
        {smbAddr, eepAddr, smbData, eepData} <= {a, a, d, d};
        @(posedge clk);
        {smbWrEn, eepWrEn} <= 2'h0;
        {smbAddr, eepAddr, smbData, eepData} <= {~a, ~a, ~d, ~d};
    endtask

    // A tidy configurer fills reserved places with zero; it never reads gaps
    task automatic clearReserved(input logic viaEep);
        writeByte(viaEep, OFS_RSVD_E0, 8'h00);
        writeByte(viaEep, OFS_RSVD_F5, 8'h00);
    endtask

    // Load finished pulse
    task automatic finishLoad();
        @(posedge clk);
        loadComplete <= 1'b1;
        @(posedge clk);
        loadComplete <= 1'b0;
    endtask
endmodule

// >>> hcr_config_register_set_tb.sv
// Self-checking bench for the hub configuration register set
`timescale 1ns/10ps
module hcr_config_register_set_tb;
    import hcr_pkg::*;
    logic clk, rst_b, rdEn, rdValid, configDone, smbWrEn, eepWrEn, loadComplete;
    logic [1:0] cfgSelPins;
    logic [3:0] strap, portPowerDrive;
    logic [7:0] smbAddr, smbData, eepAddr, eepData, rdAddr, rdData, d;
    logic [7:0] cfgByteOne, cfgByteTwo, cfgByteThree;
    logic [7:0] powerBudgetSelf, powerBudgetBus, powerSettleTime;
    logic [15:0] vendorId, productId, releaseNumber;
    hcr_source_e cfgSource;
    logic [7:0] expQ[$];
    logic [7:0] img[6];
    logic [7:0] locs[16] = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h53, 8'h54, 8'h91, 8'h92,
        8'hCF, 8'hE0, 8'hF6, 8'hF8, 8'hFA, 8'hFB, 8'hFC, 8'hFF};
    int miscompares = 0;
    int checksDone = 0;
    int seed = 75;

    hcr_config_register_set i_dut (.clk, .rst_b, .cfgSelPins, .chargeEnableStrap(strap),
        .smbWrEn, .smbAddr, .smbData, .eepWrEn, .eepAddr, .eepData, .loadComplete,
        .rdEn, .rdAddr, .rdData, .rdValid, .configDone, .cfgSource, .vendorId,
        .productId, .releaseNumber, .cfgByteOne, .cfgByteTwo, .cfgByteThree,
        .powerBudgetSelf, .powerBudgetBus, .powerSettleTime, .portPowerDrive);
    hcr_cfg_host i_host (.clk, .smbWrEn, .smbAddr, .smbData, .eepWrEn, .eepAddr,
        .eepData, .loadComplete);

    // Clock and time-zero inputs
    initial begin
        {clk, rst_b, rdEn, cfgSelPins, strap, rdAddr} = 0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic giveVerdict();
        $display("checks %0d, mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Past the edge so its updates have landed
    task automatic settle();
        @(posedge clk);
        #1;
    endtask

    // Select pins held through reset; captured after release
    task automatic doReset(input logic [1:0] m);
        @(posedge clk);
        rst_b <= 1'b0;
        cfgSelPins <= m;
        strap <= 4'($random(seed));
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) settle();
    endtask

    // Read request; the expected byte waits in the queue
    task automatic readExp(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rdEn <= 1'b1;
        rdAddr <= a;
        expQ.push_back(e);
        @(posedge clk);
        rdEn <= 1'b0;
        rdAddr <= ~a;
    endtask

    // Read monitor pairs each valid byte with the oldest note
    always @(posedge clk) begin
        if (rdValid === 1'b1) begin
            if (expQ.size() == 0) begin
                check("rdValid", 16'h1, 16'h0);
            end else begin
                check("rdData", 16'(rdData), 16'(expQ.pop_front()));
            end
        end
    end

    // Hang guard, well past the expected run
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        giveVerdict();
    end

    initial begin
        // Internal modes: built-in image, strap-driven port power
        for (int m = 0; m < 3; m += 2) begin
            doReset(2'(m));
            check("cfgSource", 16'(cfgSource), 16'(m));
            check("configDone", 16'(configDone), 16'h1);
            check("cfgByteOne", 16'(cfgByteOne), 16'(DEF_CFG_ONE));
            check("cfgByteTwo", 16'(cfgByteTwo), 16'(DEF_CFG_TWO));
            check("cfgByteThree", 16'(cfgByteThree), 16'(DEF_CFG_THREE));
            check("budgetSelf", 16'(powerBudgetSelf), 16'(DEF_BUDGET_SELF));
            check("budgetBus", 16'(powerBudgetBus), 16'(DEF_BUDGET_BUS));
            check("settleTime", 16'(powerSettleTime), 16'(DEF_SETTLE_TIME));
            check("portPowerDrive", 16'(portPowerDrive), 16'(strap));
            readExp(OFS_CFG_THREE, DEF_CFG_THREE);
            readExp(OFS_CURRENT_SELF, DEF_BUDGET_SELF);
            readExp(OFS_CURRENT_BUS, DEF_BUDGET_BUS);
            $display("internal mode %0d test done", m);
        end
        // External modes: zero image, one map for both paths; one gap read against zero
        for (int m = 1; m < 4; m += 2) begin
            doReset(2'(m));
            check("configDone", 16'(configDone), 16'h0);
            check("cfgSource", 16'(cfgSource), 16'(m));
            check("vendorId", vendorId, 16'h0000);
            readExp(OFS_SERIAL_LAST, RST_IMAGE);
            readExp(8'hE5, RST_IMAGE);
            i_host.writeByte(m == 1, OFS_CFG_ONE, 8'h5A);
            for (int i = 0; i < 6; i++) begin
                img[i] = 8'($random(seed));
                i_host.writeByte(m == 3, 8'(i), img[i]);
            end
            settle();
            check("cfgByteOne", 16'(cfgByteOne), 16'h0000);
            check("vendorId", vendorId, {img[1], img[0]});
            check("productId", productId, {img[3], img[2]});
            check("releaseNumber", releaseNumber, {img[5], img[4]});
            foreach (locs[k]) begin
                d = 8'($random(seed));
                i_host.writeByte(m == 3, locs[k], d);
                readExp(locs[k], (locs[k] == OFS_STATUS_CMD && m == 3) ? 8'h00 : d);
            end
            i_host.clearReserved(m == 3);
            readExp(OFS_RSVD_E0, 8'h00);
            i_host.writeByte(m == 3, OFS_CHARGE_EN, 8'h15);
            settle();
            check("portPowerDrive", 16'(portPowerDrive), 16'h0);
            i_host.finishLoad();
            repeat (3) settle();
            check("configDone", 16'(configDone), 16'h1);
            check("portPowerDrive", 16'(portPowerDrive), 16'hA);
            $display("external mode %0d test done", m);
        end
        repeat (3) @(posedge clk);
        // Every noted read must have been answered
        check("pendingReads", 16'(expQ.size()), 16'h0);
        giveVerdict();
    end
endmodule
